// ===== shared/rre_pkg.sv
// Constants, carriers and state record for the replay-protected block request engine.
// Assumes one clock domain; the key and counter live in a nonvolatile store outside.
package rre_pkg;

	localparam logic [15:0] REQ_PROGRAM_KEY = 16'h0001;
	localparam logic [15:0] REQ_GET_COUNTER = 16'h0002;
	localparam logic [15:0] REQ_DATA_WRITE = 16'h0003;
	localparam logic [15:0] REQ_DATA_READ = 16'h0004;
	localparam logic [15:0] REQ_RESULT_READ = 16'h0005;
	localparam logic [15:0] RESP_PROGRAM_KEY = 16'h0100;
	localparam logic [15:0] RESP_GET_COUNTER = 16'h0200;
	localparam logic [15:0] RESP_DATA_WRITE = 16'h0300;
	localparam logic [15:0] RESP_DATA_READ = 16'h0400;
	localparam logic [15:0] RESP_NONE = 16'h0000;

	localparam logic [15:0] RES_OK = 16'h0000;
	localparam logic [15:0] RES_GENERAL_FAILURE = 16'h0001;
	localparam logic [15:0] RES_AUTH_FAILURE = 16'h0002;
	localparam logic [15:0] RES_COUNT_FAILURE = 16'h0003;
	localparam logic [15:0] RES_ADDR_FAILURE = 16'h0004;
	localparam logic [15:0] RES_WRITE_FAILURE = 16'h0005;
	localparam logic [15:0] RES_READ_FAILURE = 16'h0006;
	localparam logic [15:0] RES_NO_AUTH_KEY = 16'h0007;
	localparam logic [15:0] RES_COUNTER_EXPIRED = 16'h0080;

	localparam logic [31:0] CNT_MAX = 32'hFFFF_FFFF;
	localparam logic [15:0] ONE_BLOCK = 16'h0001;
	// 128 KB capacity unit holds 512 blocks of 256 bytes
	localparam int CAP_UNIT_SHIFT = 9;

	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_WCNT = 4'h8;
	localparam logic [3:0] REG_LAST = 4'hC;
	localparam int CFG_CAP_LSB = 0;
	localparam int CFG_MAXWR_LSB = 8;
	localparam int STAT_KEY_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam logic [7:0] CAP_RST = 8'h80;
	localparam logic [7:0] MAXWR_RST = 8'h00;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MAC = 2'b01,
		ST_STOR = 2'b10
	} rre_state_e;

	typedef struct packed {
		logic [15:0] req_type;
		logic [15:0] block_count;
		logic [15:0] address;
		logic [31:0] write_counter;
	} rre_req_s;

	typedef struct packed {
		logic [15:0] req_resp;
		logic [15:0] result;
		logic [31:0] write_counter;
		logic [15:0] address;
		logic [15:0] block_count;
	} rre_rsp_s;

	typedef struct packed {
		rre_state_e st;
		rre_req_s req;
		logic req_ready;
		logic rsp_valid;
		rre_rsp_s rsp;
		rre_rsp_s last_wr;
		logic [31:0] counter;
		logic key_set;
		logic loaded;
		logic [7:0] capacity;
		logic [7:0] max_wr;
		logic [15:0] last_result;
		logic [31:0] rdata;
		logic mac_start;
		logic stor_wr;
		logic stor_rd;
		logic nv_wr;
	} rre_regs_s;

endpackage

// ===== hw/rre_engine.sv
// Request engine for a replay-protected block store: checks, counter and result frames.
// Assumes an outside HMAC core holding the key, a block store, and a nonvolatile key/counter.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ns
module rre_engine
	import rre_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic req_valid,
	input wire rre_req_s req,
	output logic req_ready,
	output logic rsp_valid,
	output rre_rsp_s rsp,
	output logic mac_start,
	input wire logic mac_done,
	input wire logic mac_match,
	output logic stor_wr,
	output logic stor_rd,
	output logic [15:0] stor_addr,
	output logic [15:0] stor_blocks,
	input wire logic stor_done,
	input wire logic stor_fail,
	input wire logic stor_fault,
	input wire logic nv_key_set,
	input wire logic [31:0] nv_counter,
	output logic nv_wr,
	output logic [31:0] nv_wr_counter
);

	localparam rre_regs_s RST = '{
		st: ST_IDLE,
		req: '0,
		req_ready: 1'b0,
		rsp_valid: 1'b0,
		rsp: '0,
		last_wr: '0,
		counter: '0,
		key_set: 1'b0,
		loaded: 1'b0,
		capacity: CAP_RST,
		max_wr: MAXWR_RST,
		last_result: RES_OK,
		rdata: '0,
		mac_start: 1'b0,
		stor_wr: 1'b0,
		stor_rd: 1'b0,
		nv_wr: 1'b0
	};

	rre_regs_s r_ff;
	rre_regs_s nxt_r;
	logic take;

	// Range check: blocks [addr, addr+count) must lie inside capacity
	function automatic logic addr_ok(input logic [15:0] addr, input logic [15:0] cnt,
		input logic [7:0] cap);
		logic [17:0] top;
		logic [17:0] lim;
		top = {2'b00, addr} + {2'b00, cnt};
		lim = 18'({10'h000, cap} << CAP_UNIT_SHIFT);
		return top <= lim;
	endfunction

	function automatic rre_rsp_s mk_rsp(input logic [15:0] typ, input logic [15:0] res,
		input logic [31:0] cnt, input rre_req_s q);
		rre_rsp_s o;
		o.req_resp = typ;
		o.result = res;
		o.write_counter = cnt;
		o.address = q.address;
		o.block_count = q.block_count;
		return o;
	endfunction

	assign take = r_ff.req_ready & req_valid;

	always_comb begin
		nxt_r = r_ff;
		nxt_r.rsp_valid = 1'b0;
		nxt_r.mac_start = 1'b0;
		nxt_r.stor_wr = 1'b0;
		nxt_r.stor_rd = 1'b0;
		nxt_r.nv_wr = 1'b0;
		nxt_r.rdata = '0;

		// Key and counter come back from the nonvolatile store after each reset
		if (!r_ff.loaded) begin
			nxt_r.key_set = nv_key_set;
			nxt_r.counter = nv_counter;
			nxt_r.loaded = 1'b1;
		end

		if (reg_wr && reg_addr == REG_CFG) begin
			nxt_r.capacity = reg_wdata[CFG_CAP_LSB +: 8];
			nxt_r.max_wr = reg_wdata[CFG_MAXWR_LSB +: 8];
		end
		// Counter is readable only; no key bits are ever readable
		if (reg_rd) begin
			case (reg_addr)
				REG_CFG: begin
					nxt_r.rdata = {16'h0000, r_ff.max_wr, r_ff.capacity};
				end
				REG_STAT: begin
					nxt_r.rdata[STAT_KEY_BIT] = r_ff.key_set;
					nxt_r.rdata[STAT_BUSY_BIT] = r_ff.st != ST_IDLE;
				end
				REG_WCNT: begin
					nxt_r.rdata = r_ff.counter;
				end
				REG_LAST: begin
					nxt_r.rdata = {16'h0000, r_ff.last_result};
				end
				default: begin
					nxt_r.rdata = '0;
				end
			endcase
		end

		case (r_ff.st)
			ST_IDLE: begin
				if (take) begin
					nxt_r.req = req;
					case (req.req_type)
						REQ_GET_COUNTER: begin
							nxt_r.rsp_valid = 1'b1;
							if (!r_ff.key_set) begin
								nxt_r.rsp = mk_rsp(RESP_GET_COUNTER, RES_NO_AUTH_KEY,
									r_ff.counter, req);
							end else if (req.block_count != ONE_BLOCK) begin
								nxt_r.rsp = mk_rsp(RESP_GET_COUNTER, RES_GENERAL_FAILURE,
									r_ff.counter, req);
							end else begin
								nxt_r.rsp = mk_rsp(RESP_GET_COUNTER, RES_OK,
									r_ff.counter, req);
							end
						end
						REQ_DATA_WRITE: begin
							// Checks in fixed priority, first failure wins
							if (!r_ff.key_set) begin
								nxt_r.last_wr = mk_rsp(RESP_DATA_WRITE, RES_NO_AUTH_KEY,
									r_ff.counter, req);
							end else if (req.block_count == 16'h0000 || (r_ff.max_wr != 8'h00 &&
								req.block_count > {8'h00, r_ff.max_wr})) begin
								nxt_r.last_wr = mk_rsp(RESP_DATA_WRITE, RES_GENERAL_FAILURE,
									r_ff.counter, req);
							end else if (r_ff.counter == CNT_MAX) begin
								nxt_r.last_wr = mk_rsp(RESP_DATA_WRITE, RES_COUNTER_EXPIRED,
									r_ff.counter, req);
							end else if (!addr_ok(req.address, req.block_count, r_ff.capacity)) begin
								nxt_r.last_wr = mk_rsp(RESP_DATA_WRITE, RES_ADDR_FAILURE,
									r_ff.counter, req);
							end else begin
								nxt_r.mac_start = 1'b1;
								nxt_r.st = ST_MAC;
							end
						end
						REQ_DATA_READ: begin
							if (!r_ff.key_set) begin
								nxt_r.rsp_valid = 1'b1;
								nxt_r.rsp = mk_rsp(RESP_DATA_READ, RES_NO_AUTH_KEY,
									r_ff.counter, req);
							end else if (req.block_count != ONE_BLOCK) begin
								nxt_r.rsp_valid = 1'b1;
								nxt_r.rsp = mk_rsp(RESP_DATA_READ, RES_GENERAL_FAILURE,
									r_ff.counter, req);
							end else if (!addr_ok(req.address, req.block_count, r_ff.capacity)) begin
								nxt_r.rsp_valid = 1'b1;
								nxt_r.rsp = mk_rsp(RESP_DATA_READ, RES_ADDR_FAILURE,
									r_ff.counter, req);
							end else begin
								nxt_r.stor_rd = 1'b1;
								nxt_r.st = ST_STOR;
							end
						end
						REQ_RESULT_READ: begin
							nxt_r.rsp_valid = 1'b1;
							nxt_r.rsp = r_ff.last_wr;
							if (req.block_count != ONE_BLOCK) begin
								nxt_r.rsp.result = RES_GENERAL_FAILURE;
							end
						end
						default: begin
							nxt_r.rsp_valid = 1'b1;
							nxt_r.rsp = mk_rsp(RESP_NONE, RES_GENERAL_FAILURE, r_ff.counter, req);
						end
					endcase
				end
			end
			ST_MAC: begin
				if (mac_done) begin
					nxt_r.st = ST_IDLE;
					if (!mac_match) begin
						nxt_r.last_wr = mk_rsp(RESP_DATA_WRITE, RES_AUTH_FAILURE,
							r_ff.counter, r_ff.req);
					end else if (r_ff.req.write_counter != r_ff.counter) begin
						nxt_r.last_wr = mk_rsp(RESP_DATA_WRITE, RES_COUNT_FAILURE,
							r_ff.counter, r_ff.req);
					end else begin
						nxt_r.stor_wr = 1'b1;
						nxt_r.st = ST_STOR;
					end
				end
			end
			ST_STOR: begin
				if (stor_done) begin
					nxt_r.st = ST_IDLE;
					if (r_ff.req.req_type == REQ_DATA_WRITE) begin
						if (stor_fail) begin
							nxt_r.last_wr = mk_rsp(RESP_DATA_WRITE, RES_WRITE_FAILURE,
								r_ff.counter, r_ff.req);
						end else if (stor_fault) begin
							nxt_r.last_wr = mk_rsp(RESP_DATA_WRITE, RES_GENERAL_FAILURE,
								r_ff.counter, r_ff.req);
						end else begin
							// Expiry was refused earlier, so the step never wraps
							nxt_r.counter = r_ff.counter + 32'h0000_0001;
							nxt_r.nv_wr = 1'b1;
							nxt_r.last_wr = mk_rsp(RESP_DATA_WRITE, RES_OK,
								r_ff.counter + 32'h0000_0001, r_ff.req);
						end
					end else begin
						nxt_r.rsp_valid = 1'b1;
						if (stor_fail) begin
							nxt_r.rsp = mk_rsp(RESP_DATA_READ, RES_READ_FAILURE,
								r_ff.counter, r_ff.req);
						end else if (stor_fault) begin
							nxt_r.rsp = mk_rsp(RESP_DATA_READ, RES_GENERAL_FAILURE,
								r_ff.counter, r_ff.req);
						end else begin
							nxt_r.rsp = mk_rsp(RESP_DATA_READ, RES_OK,
								r_ff.counter, r_ff.req);
						end
					end
				end
			end
			default: begin
				nxt_r.st = ST_IDLE;
			end
		endcase

		if (nxt_r.rsp_valid) begin
			nxt_r.last_result = nxt_r.rsp.result;
		end else if (nxt_r.last_wr != r_ff.last_wr) begin
			nxt_r.last_result = nxt_r.last_wr.result;
		end
		nxt_r.req_ready = nxt_r.loaded && nxt_r.st == ST_IDLE && !take;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_ff <= RST;
		end else if (ce) begin
			r_ff <= nxt_r;
		end
	end

	assign reg_rdata = r_ff.rdata;
	assign req_ready = r_ff.req_ready;
	assign rsp_valid = r_ff.rsp_valid;
	assign rsp = r_ff.rsp;
	assign mac_start = r_ff.mac_start;
	assign stor_wr = r_ff.stor_wr;
	assign stor_rd = r_ff.stor_rd;
	assign stor_addr = r_ff.req.address;
	assign stor_blocks = r_ff.req.block_count;
	assign nv_wr = r_ff.nv_wr;
	assign nv_wr_counter = r_ff.counter;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_GC_NO_KEY: assert property (
		ce && take && req.req_type == REQ_GET_COUNTER && !r_ff.key_set
		|=> rsp_valid && rsp.result == RES_NO_AUTH_KEY)
		else $error("get-counter without key not refused");
	AST_GC_COUNT: assert property (
		ce && take && req.req_type == REQ_GET_COUNTER && r_ff.key_set && req.block_count != ONE_BLOCK
		|=> rsp_valid && rsp.result == RES_GENERAL_FAILURE)
		else $error("get-counter block total not checked");
	AST_GC_TYPE: assert property (
		ce && take && req.req_type == REQ_GET_COUNTER
		|=> rsp_valid && rsp.req_resp == RESP_GET_COUNTER && rsp.write_counter == $past(r_ff.counter))
		else $error("get-counter answer wrong");
	AST_EXPIRED: assert property (
		ce && take && req.req_type == REQ_DATA_WRITE && r_ff.key_set &&
		req.block_count == ONE_BLOCK && r_ff.counter == CNT_MAX
		|=> r_ff.st == ST_IDLE && r_ff.last_wr.result == RES_COUNTER_EXPIRED)
		else $error("expired counter not reported");
	AST_AUTH: assert property (
		ce && r_ff.st == ST_MAC && mac_done && !mac_match
		|=> !stor_wr && r_ff.last_wr.result == RES_AUTH_FAILURE)
		else $error("MAC mismatch not reported");
	AST_CNT_FAIL: assert property (
		ce && r_ff.st == ST_MAC && mac_done && mac_match && r_ff.req.write_counter != r_ff.counter
		|=> !stor_wr && r_ff.last_wr.result == RES_COUNT_FAILURE)
		else $error("counter mismatch not reported");
	AST_CNT_STEP: assert property (
		$past(r_ff.loaded) && r_ff.counter != $past(r_ff.counter)
		|-> r_ff.counter == $past(r_ff.counter) + 32'h0000_0001 && nv_wr)
		else $error("counter moved by other than one");
	AST_SAT: assert property (
		r_ff.loaded && r_ff.counter == CNT_MAX |=> r_ff.counter == CNT_MAX)
		else $error("counter left saturation");
	AST_WR_FAIL: assert property (
		ce && r_ff.st == ST_STOR && r_ff.req.req_type == REQ_DATA_WRITE && stor_done && stor_fail
		|=> r_ff.last_wr.result == RES_WRITE_FAILURE && $stable(r_ff.counter))
		else $error("write failure not reported");
	AST_RR_COUNT: assert property (
		ce && take && req.req_type == REQ_RESULT_READ && req.block_count != ONE_BLOCK
		|=> rsp_valid && rsp.result == RES_GENERAL_FAILURE)
		else $error("result read block total not checked");
	AST_WR_TOTAL: assert property (
		ce && take && req.req_type == REQ_DATA_WRITE && r_ff.key_set &&
		(req.block_count == 16'h0000 ||
		(r_ff.max_wr != 8'h00 && req.block_count > {8'h00, r_ff.max_wr}))
		|=> r_ff.st == ST_IDLE && r_ff.last_wr.result == RES_GENERAL_FAILURE)
		else $error("write block total not checked");
	AST_WR_ADDR: assert property (
		ce && take && req.req_type == REQ_DATA_WRITE && r_ff.key_set &&
		r_ff.counter != CNT_MAX && req.block_count != 16'h0000 &&
		(r_ff.max_wr == 8'h00 || req.block_count <= {8'h00, r_ff.max_wr}) &&
		{2'b00, req.address} + {2'b00, req.block_count} > {1'b0, r_ff.capacity, 9'h000}
		|=> r_ff.st == ST_IDLE && r_ff.last_wr.result == RES_ADDR_FAILURE)
		else $error("write outside range not refused");
	AST_RD_ADDR: assert property (
		ce && take && req.req_type == REQ_DATA_READ && r_ff.key_set &&
		req.block_count == ONE_BLOCK && {1'b0, req.address} >= {r_ff.capacity, 9'h000}
		|=> rsp_valid && rsp.req_resp == RESP_DATA_READ && rsp.result == RES_ADDR_FAILURE)
		else $error("read outside range not refused");
	AST_RD_NO_KEY: assert property (
		ce && take && req.req_type == REQ_DATA_READ && !r_ff.key_set
		|=> rsp_valid && rsp.result == RES_NO_AUTH_KEY)
		else $error("read without key not refused");
	AST_WR_ORDER: assert property (
		ce && take && req.req_type == REQ_DATA_WRITE && !r_ff.key_set
		|=> r_ff.st == ST_IDLE && r_ff.last_wr.result == RES_NO_AUTH_KEY)
		else $error("missing key not reported first");
	AST_STOR_GATE: assert property (
		$rose(stor_wr) |-> $past(mac_done) && $past(mac_match) &&
		$past(r_ff.req.write_counter) == $past(r_ff.counter))
		else $error("store started without authentication");
	AST_WR_OK: assert property (
		ce && r_ff.st == ST_STOR && r_ff.req.req_type == REQ_DATA_WRITE && stor_done &&
		!stor_fail && !stor_fault
		|=> r_ff.counter == $past(r_ff.counter) + 32'h0000_0001 && nv_wr && r_ff.last_wr.result == RES_OK)
		else $error("successful write did not step counter");
	AST_WR_TYPE: assert property (
		r_ff.last_wr != $past(r_ff.last_wr) |-> r_ff.last_wr.req_resp == RESP_DATA_WRITE)
		else $error("write answer type wrong");
	AST_WR_FAULT: assert property (
		ce && r_ff.st == ST_STOR && r_ff.req.req_type == REQ_DATA_WRITE && stor_done && !stor_fail &&
		stor_fault |=> r_ff.last_wr.result == RES_GENERAL_FAILURE && $stable(r_ff.counter))
		else $error("write fault not reported");
	AST_RD_FAIL: assert property (
		ce && r_ff.st == ST_STOR && r_ff.req.req_type == REQ_DATA_READ && stor_done && stor_fail
		|=> rsp_valid && rsp.result == RES_READ_FAILURE)
		else $error("read failure not reported");
	AST_RD_FAULT: assert property (
		ce && r_ff.st == ST_STOR && r_ff.req.req_type == REQ_DATA_READ && stor_done && !stor_fail &&
		stor_fault |=> rsp_valid && rsp.result == RES_GENERAL_FAILURE)
		else $error("read fault not reported");
	AST_RD_TYPE: assert property (
		ce && r_ff.st == ST_STOR && r_ff.req.req_type == REQ_DATA_READ && stor_done
		|=> rsp_valid && rsp.req_resp == RESP_DATA_READ)
		else $error("read answer type wrong");
	AST_RR_FRAME: assert property (
		ce && take && req.req_type == REQ_RESULT_READ && req.block_count == ONE_BLOCK
		|=> rsp_valid && rsp == $past(r_ff.last_wr))
		else $error("result read frame wrong");
	AST_LAST: assert property (
		rsp_valid |-> r_ff.last_result == rsp.result)
		else $error("last result not recorded");
	AST_KEY: assert property (
		r_ff.loaded |=> r_ff.key_set == $past(r_ff.key_set))
		else $error("key state changed after load");

endmodule

// ===== verif/rre_far_model.sv
// Far-side model: MAC core holding the key, block store, nonvolatile key and counter.
// Assumes one clock; the bench steers delay, MAC verdict, store faults and preload.
`timescale 1ns/1ns
module rre_far_model (
	input wire logic clk,
	input wire logic slow,
	input wire logic mac_ok,
	input wire logic [1:0] fail_sel,
	input wire logic load,
	input wire logic key_in,
	input wire logic [31:0] cnt_in,
	input wire logic mac_start,
	input wire logic stor_wr,
	input wire logic stor_rd,
	input wire logic nv_wr,
	input wire logic [31:0] nv_wr_counter,
	output logic mac_done = 1'b0,
	output logic mac_match = 1'b0,
	output logic stor_done = 1'b0,
	output logic stor_fail = 1'b0,
	output logic stor_fault = 1'b0,
	output logic nv_key_set = 1'b0,
	output logic [31:0] nv_counter = 32'h0
);
	logic [3:0] mac_t = 4'h0;
	logic [3:0] stor_t = 4'h0;

	// Answers after one cycle, or six when stalling; flags toggle when not valid
	always @(posedge clk) begin
		mac_done <= 1'b0;
		stor_done <= 1'b0;
		mac_match <= ~mac_match;
		stor_fail <= ~stor_fail;
		stor_fault <= ~stor_fault;
		if (mac_start) begin
			mac_t <= slow ? 4'h6 : 4'h1;
		end else if (mac_t != 4'h0) begin
			mac_t <= mac_t - 4'h1;
		end
		if (mac_t == 4'h1) begin
			mac_done <= 1'b1;
			mac_match <= mac_ok;
		end
		if (stor_wr || stor_rd) begin
			stor_t <= slow ? 4'h6 : 4'h1;
		end else if (stor_t != 4'h0) begin
			stor_t <= stor_t - 4'h1;
		end
		if (stor_t == 4'h1) begin
			stor_done <= 1'b1;
			stor_fail <= fail_sel[0];
			stor_fault <= fail_sel[1];
		end
		// No reset input: key and counter outlive every reset
		if (load) begin
			nv_key_set <= key_in;
			nv_counter <= cnt_in;
		end else if (nv_wr) begin
			nv_counter <= nv_wr_counter;
		end
	end
endmodule

// ===== verif/testbench.sv
// Self-checking bench: register and request tasks, sequences with expected results.
// Assumes the far-side model for MAC core, block store and nonvolatile store.
`timescale 1ns/1ns
module testbench;
	import rre_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ce = 1'b1;
	logic req_valid = 1'b0;
	rre_req_s req = '0;
	logic slow = 1'b0;
	logic mac_ok = 1'b1;
	logic load = 1'b0;
	logic key_in = 1'b0;
	logic [1:0] fail_sel = 2'h0;
	logic [31:0] cnt_in = 32'h0;
	logic [31:0] reg_rdata, nv_counter, nv_wr_counter;
	logic req_ready, rsp_valid, mac_start, mac_done, mac_match, stor_wr, stor_rd;
	logic stor_done, stor_fail, stor_fault, nv_key_set, nv_wr;
	rre_rsp_s rsp;
	logic [15:0] stor_addr, stor_blocks;
	int fail_count = 0;
	int comparisons = 0;

	always #4 clk = ~clk;

	rre_engine dut_u (.clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .req_valid, .req, .req_ready, .rsp_valid, .rsp, .mac_start, .mac_done,
		.mac_match, .stor_wr, .stor_rd, .stor_addr, .stor_blocks, .stor_done,
		.stor_fail, .stor_fault, .nv_key_set, .nv_counter, .nv_wr, .nv_wr_counter);
	rre_far_model far_u (.clk, .slow, .mac_ok, .fail_sel, .load, .key_in, .cnt_in,
		.mac_start, .stor_wr, .stor_rd, .nv_wr, .nv_wr_counter, .mac_done, .mac_match,
		.stor_done, .stor_fail, .stor_fault, .nv_key_set, .nv_counter);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_w(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_r(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, e);
	endtask

	// Request held until the edge that sees ready high
	task automatic send(input logic [15:0] t, c, a, input logic [31:0] w);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{t, c, a, w};
		@(negedge clk);
		for (int i = 0; i < 200 && req_ready !== 1'b1; i++) @(negedge clk);
		@(posedge clk);
		req_valid <= 1'b0;
	endtask

	// A write is followed by a result read that fetches its frame
	task automatic run(input logic [15:0] t, c, a, input logic [31:0] w,
		input logic [15:0] eres);
		logic [15:0] et;
		et = (t === REQ_GET_COUNTER) ? RESP_GET_COUNTER :
			(t === REQ_DATA_READ) ? RESP_DATA_READ :
			(t === REQ_PROGRAM_KEY) ? RESP_NONE : RESP_DATA_WRITE;
		send(t, c, a, w);
		if (t === REQ_DATA_WRITE) send(REQ_RESULT_READ, ONE_BLOCK, 16'h0, 32'h0);
		@(negedge clk);
		for (int i = 0; i < 100 && rsp_valid !== 1'b1; i++) @(negedge clk);
		chk(32'(rsp_valid), 32'h1);
		chk(32'(rsp.req_resp), 32'(et));
		chk(32'(rsp.result), 32'(eres));
	endtask

	task automatic reboot(input logic k, input logic [31:0] c);
		@(posedge clk);
		rst_n <= 1'b0;
		load <= 1'b1;
		key_in <= k;
		cnt_in <= c;
		@(posedge clk);
		load <= 1'b0;
		repeat (19) @(posedge clk);
		rst_n <= 1'b1;
	endtask

	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		fail_count++;
		end_sim;
	end

	initial begin
		reboot(1'b0, 32'h0);
		reg_r(REG_CFG, 32'h80);
		reg_r(REG_STAT, 32'h0);
		reg_r(4'h2, 32'h0);
		run(REQ_GET_COUNTER, ONE_BLOCK, 16'h0, 32'h0, RES_NO_AUTH_KEY);
		run(REQ_DATA_READ, ONE_BLOCK, 16'h0, 32'h0, RES_NO_AUTH_KEY);
		run(REQ_DATA_WRITE, 16'h0, 16'h0, 32'h0, RES_NO_AUTH_KEY);
		reboot(1'b1, 32'h5);
		reg_r(REG_STAT, 32'h1);
		reg_w(REG_WCNT, 32'h0);
		reg_r(REG_WCNT, 32'h5);
		// Frozen engine must ignore the read strobe
		@(posedge clk);
		ce <= 1'b0;
		reg_r(REG_WCNT, 32'h0);
		@(posedge clk);
		ce <= 1'b1;
		run(REQ_PROGRAM_KEY, ONE_BLOCK, 16'h0, 32'h0, RES_GENERAL_FAILURE);
		reg_r(REG_STAT, 32'h1);
		run(REQ_GET_COUNTER, 16'h2, 16'h0, 32'h0, RES_GENERAL_FAILURE);
		run(REQ_GET_COUNTER, ONE_BLOCK, 16'h0, 32'h0, RES_OK);
		chk(rsp.write_counter, 32'h5);
		run(REQ_DATA_READ, 16'h0, 16'h10, 32'h0, RES_GENERAL_FAILURE);
		slow <= 1'b1;
		run(REQ_DATA_READ, ONE_BLOCK, 16'h10, 32'h0, RES_OK);
		chk(32'(stor_addr), 32'h10);
		chk(32'(stor_blocks), 32'h1);
		fail_sel <= 2'h1;
		run(REQ_DATA_READ, ONE_BLOCK, 16'h10, 32'h0, RES_READ_FAILURE);
		fail_sel <= 2'h2;
		run(REQ_DATA_READ, ONE_BLOCK, 16'h10, 32'h0, RES_GENERAL_FAILURE);
		fail_sel <= 2'h0;
		run(REQ_DATA_WRITE, 16'h0, 16'h20, 32'h5, RES_GENERAL_FAILURE);
		reg_w(REG_CFG, 32'h280);
		run(REQ_DATA_WRITE, 16'h3, 16'h20, 32'h5, RES_GENERAL_FAILURE);
		reg_w(REG_CFG, 32'h201);
		reg_r(REG_CFG, 32'h201);
		run(REQ_DATA_WRITE, 16'h2, 16'h1FF, 32'h5, RES_ADDR_FAILURE);
		run(REQ_DATA_READ, ONE_BLOCK, 16'h200, 32'h0, RES_ADDR_FAILURE);
		reg_w(REG_CFG, 32'h80);
		mac_ok <= 1'b0;
		run(REQ_DATA_WRITE, ONE_BLOCK, 16'h20, 32'h4, RES_AUTH_FAILURE);
		mac_ok <= 1'b1;
		run(REQ_DATA_WRITE, ONE_BLOCK, 16'h20, 32'h4, RES_COUNT_FAILURE);
		reg_r(REG_WCNT, 32'h5);
		run(REQ_DATA_WRITE, 16'h2, 16'h20, 32'h5, RES_OK);
		chk(rsp.write_counter, 32'h6);
		chk(32'(rsp.address), 32'h20);
		chk(nv_counter, 32'h6);
		// Last frame holds success, so the bad total must show as a failure
		run(REQ_RESULT_READ, 16'h2, 16'h0, 32'h0, RES_GENERAL_FAILURE);
		fail_sel <= 2'h1;
		run(REQ_DATA_WRITE, ONE_BLOCK, 16'h30, 32'h6, RES_WRITE_FAILURE);
		reg_r(REG_LAST, 32'h5);
		fail_sel <= 2'h2;
		run(REQ_DATA_WRITE, ONE_BLOCK, 16'h30, 32'h6, RES_GENERAL_FAILURE);
		fail_sel <= 2'h0;
		reg_r(REG_WCNT, 32'h6);
		reboot(1'b1, CNT_MAX);
		reg_r(REG_CFG, 32'h80);
		run(REQ_DATA_WRITE, 16'h0, 16'h20, CNT_MAX, RES_GENERAL_FAILURE);
		run(REQ_DATA_WRITE, ONE_BLOCK, 16'h20, CNT_MAX, RES_COUNTER_EXPIRED);
		reg_r(REG_WCNT, CNT_MAX);
		end_sim;
	end
endmodule
